//--- fbe_flash_ctrl.sv
`timescale 1ns/1ps
`include "fbe_regs.svh"

module fbe_flash_ctrl #(
  parameter fbe_pkg::fbe_opcode_type FACTORY_ERASE_BOOST_CMD = 8'h32,
  parameter fbe_pkg::fbe_opcode_type WRITE_ENABLE_CMD = 8'h06,
  parameter fbe_pkg::fbe_opcode_type HALF_BLOCK_ERASE_CMD = 8'h52,
  parameter fbe_pkg::fbe_opcode_type BLOCK_ERASE_CMD = 8'hD8,
  parameter fbe_pkg::fbe_opcode_type CHIP_ERASE_CMD = 8'h60,
  parameter int unsigned POWER_UP_SELECT_DELAY_US = 800,
  parameter int unsigned HALF_ERASE_US = 1000,
  parameter int unsigned BLOCK_ERASE_US = 2000,
  parameter int unsigned CHIP_ERASE_US = 8000,
  parameter int unsigned HALF_ERASE_BOOST_US = 500,
  parameter int unsigned BLOCK_ERASE_BOOST_US = 1000,
  parameter int unsigned CHIP_ERASE_BOOST_US = 4000
) (
  input wire logic CLK_I,
  input wire logic RSTN_I,
  input wire logic LINK_SCLK_I,
  input wire logic LINK_CSN_I,
  input wire logic LINK_SI_I,
  output logic WRITE_LATCH_BIT_O,
  output logic BOOST_FLAG_O,
  output logic STANDBY_O,
  output logic DEEP_POWER_DOWN_O,
  output logic ERASE_BUSY_O,
  output logic ERASE_BOOSTED_O,
  output fbe_pkg::fbe_erase_type ERASE_KIND_O,
  output logic ERASE_DONE_O
);
  import fbe_pkg::*;

  // least times round up to whole core cycles, never below one
  function automatic int unsigned us_to_cycles(input int unsigned us);
    int unsigned raw;
    raw = (us * 1000 + `FBE_CLK_PERIOD_NS - 1) / `FBE_CLK_PERIOD_NS;
    return (raw < 1) ? 1 : raw;
  endfunction

  localparam int unsigned SELECT_CYCLES = us_to_cycles(POWER_UP_SELECT_DELAY_US);
  localparam int unsigned HALF_CYCLES = us_to_cycles(HALF_ERASE_US);
  localparam int unsigned BLOCK_CYCLES = us_to_cycles(BLOCK_ERASE_US);
  localparam int unsigned CHIP_CYCLES = us_to_cycles(CHIP_ERASE_US);
  localparam int unsigned HALF_BOOST_CYCLES = us_to_cycles(HALF_ERASE_BOOST_US);
  localparam int unsigned BLOCK_BOOST_CYCLES = us_to_cycles(BLOCK_ERASE_BOOST_US);
  localparam int unsigned CHIP_BOOST_CYCLES = us_to_cycles(CHIP_ERASE_BOOST_US);
  localparam logic [31:0] SELECT_LOAD = 32'(SELECT_CYCLES - 1);
  localparam logic [`FBE_BITCNT_W-1:0] SINGLE_BITS = `FBE_BITCNT_W'(`FBE_OPCODE_BITS);
  localparam logic [`FBE_BITCNT_W-1:0] ERASE_BITS = `FBE_BITCNT_W'(`FBE_ERASE_FRAME_BITS);

  // boosted erase must not be slower; the boost opcode and the write enable/chip erase pair must not alias
  generate
    if (HALF_ERASE_BOOST_US > HALF_ERASE_US || BLOCK_ERASE_BOOST_US > BLOCK_ERASE_US ||
        CHIP_ERASE_BOOST_US > CHIP_ERASE_US) begin : g_bad_timing
      $error("boosted erase time exceeds normal erase time");
    end
    if (FACTORY_ERASE_BOOST_CMD == WRITE_ENABLE_CMD || FACTORY_ERASE_BOOST_CMD == CHIP_ERASE_CMD ||
        FACTORY_ERASE_BOOST_CMD == HALF_BLOCK_ERASE_CMD || FACTORY_ERASE_BOOST_CMD == BLOCK_ERASE_CMD ||
        WRITE_ENABLE_CMD == CHIP_ERASE_CMD) begin : g_bad_opcode
      $error("command opcodes overlap");
    end
    if ((1 << `FBE_BITCNT_W) <= `FBE_ERASE_FRAME_BITS) begin : g_bad_count
      $error("frame bit counter too narrow");
    end
  endgenerate

  fbe_frame_if frm ();

  // serial shifter lives on the link clock
  fbe_link_rx u_link_rx (
    .sclk_i(LINK_SCLK_I),
    .csn_i(LINK_CSN_I),
    .si_i(LINK_SI_I),
    .rstn_i(RSTN_I),
    .frm(frm.rx)
  );

  logic csn_s1_q;
  logic csn_s2_q;
  logic csn_s3_q;
  logic frame_end;
  fbe_state_type state_q;
  logic [31:0] timer_q;
  logic wel_q;
  logic boost_q;
  logic erase_fast_q;
  fbe_erase_type erase_kind_q;
  logic done_q;
  logic cmd_single;
  logic cmd_addr;
  logic accept;
  logic write_enable_cmd_hit;
  logic boost_hit;
  fbe_erase_type start_kind;
  logic erase_start;
  logic erase_end;
  logic [31:0] start_len;

  // chip select crosses as a level; its rise is the handshake that says the
  // link words are frozen, they last changed at least two core edges earlier
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      csn_s1_q <= `FBE_CSN_IDLE;
      csn_s2_q <= `FBE_CSN_IDLE;
      csn_s3_q <= `FBE_CSN_IDLE;
    end else begin
      csn_s1_q <= LINK_CSN_I;
      csn_s2_q <= csn_s1_q;
      csn_s3_q <= csn_s2_q;
    end
  end

  assign frame_end = csn_s2_q && !csn_s3_q;

  always_comb begin
    cmd_single = (frm.bit_count == SINGLE_BITS);
    cmd_addr = (frm.bit_count == ERASE_BITS);
    // before the select delay and while erasing, frames are dropped
    accept = frame_end && (state_q == FBE_STANDBY);
    write_enable_cmd_hit = accept && cmd_single && (frm.opcode == WRITE_ENABLE_CMD);
    // boost command carries no address; only an exact 8-bit frame counts
    boost_hit = accept && cmd_single && (frm.opcode == FACTORY_ERASE_BOOST_CMD) && wel_q;
    start_kind = FBE_ERASE_NONE;
    if (accept && wel_q) begin
      if (cmd_addr && frm.opcode == HALF_BLOCK_ERASE_CMD) begin
        start_kind = FBE_ERASE_HALF;
      end else if (cmd_addr && frm.opcode == BLOCK_ERASE_CMD) begin
        start_kind = FBE_ERASE_BLOCK;
      end else if (cmd_single && frm.opcode == CHIP_ERASE_CMD) begin
        start_kind = FBE_ERASE_CHIP;
      end
    end
  end

  assign erase_start = (start_kind != FBE_ERASE_NONE);
  assign erase_end = (state_q == FBE_ERASING) && (timer_q == 32'h0000_0000);

  // accelerated timing only while the flag is set
  always_comb begin
    unique case (start_kind)
      FBE_ERASE_HALF: start_len = 32'(boost_q ? HALF_BOOST_CYCLES : HALF_CYCLES);
      FBE_ERASE_BLOCK: start_len = 32'(boost_q ? BLOCK_BOOST_CYCLES : BLOCK_CYCLES);
      FBE_ERASE_CHIP: start_len = 32'(boost_q ? CHIP_BOOST_CYCLES : CHIP_CYCLES);
      FBE_ERASE_NONE: start_len = 32'h0000_0001;
    endcase
  end

  // reset stands for supply below the inhibit threshold: an erase in flight
  // is simply dropped, the array contents are then undefined
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      state_q <= FBE_WAIT_POWER;
    end else begin
      unique case (state_q)
        FBE_WAIT_POWER: begin
          if (timer_q == 32'h0000_0000) begin
            state_q <= FBE_STANDBY;
          end
        end
        FBE_STANDBY: begin
          if (erase_start) begin
            state_q <= FBE_ERASING;
          end
        end
        FBE_ERASING: begin
          if (erase_end) begin
            state_q <= FBE_STANDBY;
          end
        end
      endcase
    end
  end

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      timer_q <= SELECT_LOAD;
    end else if (state_q == FBE_STANDBY) begin
      if (erase_start) begin
        timer_q <= start_len - 32'h0000_0001;
      end
    end else if (timer_q != 32'h0000_0000) begin
      timer_q <= timer_q - 32'h0000_0001;
    end
  end

  // latch falls when the erase it enabled completes
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      wel_q <= `FBE_LATCH_RST;
    end else if (erase_end) begin
      wel_q <= 1'b0;
    end else if (write_enable_cmd_hit) begin
      wel_q <= 1'b1;
    end
  end

  // no command is accepted during an erase, so set and clear never meet
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      boost_q <= `FBE_BOOST_RST;
    end else if (erase_end) begin
      boost_q <= 1'b0;
    end else if (boost_hit) begin
      boost_q <= 1'b1;
    end
  end

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      erase_kind_q <= FBE_ERASE_NONE;
      erase_fast_q <= 1'b0;
    end else if (erase_start) begin
      erase_kind_q <= start_kind;
      erase_fast_q <= boost_q;
    end else if (erase_end) begin
      erase_kind_q <= FBE_ERASE_NONE;
      erase_fast_q <= 1'b0;
    end
  end

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      done_q <= 1'b0;
    end else begin
      done_q <= erase_end;
    end
  end

  assign WRITE_LATCH_BIT_O = wel_q;
  assign BOOST_FLAG_O = boost_q;
  assign STANDBY_O = (state_q == FBE_STANDBY);
  // no deep power-down state exists in this block
  assign DEEP_POWER_DOWN_O = 1'b0;
  assign ERASE_BUSY_O = (state_q == FBE_ERASING);
  assign ERASE_BOOSTED_O = erase_fast_q;
  assign ERASE_KIND_O = erase_kind_q;
  assign ERASE_DONE_O = done_q;

  // independent tally of erase cycles, so the timer load is checked from outside
  logic [31:0] erase_cycles_q;

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      erase_cycles_q <= 32'h0000_0000;
    end else if (state_q != FBE_ERASING) begin
      erase_cycles_q <= 32'h0000_0001;
    end else begin
      erase_cycles_q <= erase_cycles_q + 32'h0000_0001;
    end
  end

  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!RSTN_I);

  sequence s_boost_cmd;
    frame_end && state_q == FBE_STANDBY && cmd_single && frm.opcode == FACTORY_ERASE_BOOST_CMD;
  endsequence

  sequence s_erase_go(fbe_erase_type k);
    erase_start && start_kind == k;
  endsequence

  sequence s_erase_finish;
    state_q == FBE_ERASING && timer_q == 32'h0000_0000;
  endsequence

  sequence s_finish_kind(fbe_erase_type k);
    s_erase_finish ##0 erase_kind_q == k;
  endsequence

  chk_boost_needs_latch: assert property ($rose(boost_q) |-> $past(wel_q) && $past(boost_hit))
    else $error("boost flag set without write latch");
  chk_boost_no_latch: assert property (s_boost_cmd and !wel_q and !boost_q |=> !boost_q)
    else $error("boost flag set while latch clear");
  chk_half_boosted: assert property (s_erase_go(FBE_ERASE_HALF) |=> ERASE_BOOSTED_O == $past(boost_q)
    && ERASE_KIND_O == FBE_ERASE_HALF && timer_q == 32'($past(boost_q) ? HALF_BOOST_CYCLES - 1 : HALF_CYCLES - 1))
    else $error("half block erase timing wrong");
  chk_block_boosted: assert property (s_erase_go(FBE_ERASE_BLOCK) |=> ERASE_BOOSTED_O == $past(boost_q)
    && ERASE_KIND_O == FBE_ERASE_BLOCK)
    else $error("block erase boost mode wrong");
  chk_chip_boosted: assert property (s_erase_go(FBE_ERASE_CHIP) |=> ERASE_BOOSTED_O == $past(boost_q)
    && ERASE_KIND_O == FBE_ERASE_CHIP)
    else $error("chip erase boost mode wrong");
  chk_finish_clears: assert property (s_erase_finish |=> !BOOST_FLAG_O && !WRITE_LATCH_BIT_O && ERASE_DONE_O
    && STANDBY_O ##1 !ERASE_DONE_O)
    else $error("erase completion did not clear flags");
  chk_latch_set: assert property (frame_end && state_q == FBE_STANDBY && cmd_single
    && frm.opcode == WRITE_ENABLE_CMD |=> WRITE_LATCH_BIT_O)
    else $error("write enable did not set latch");
  chk_bad_length: assert property (accept && !cmd_single && !cmd_addr |=> $stable(wel_q) && $stable(boost_q)
    && $stable(state_q))
    else $error("frame of wrong length had an effect");
  chk_power_quiet: assert property (state_q == FBE_WAIT_POWER |-> !wel_q && !boost_q && !ERASE_BUSY_O)
    else $error("commands acted before power-up delay");
  chk_standby_entry: assert property (state_q == FBE_WAIT_POWER && timer_q == 32'h0000_0000
    |=> STANDBY_O && !DEEP_POWER_DOWN_O)
    else $error("power-up did not enter standby");
  // a frame landing on the completion edge is still ignored, but the clears of that edge are legal
  chk_busy_ignores: assert property (ERASE_BUSY_O && frame_end && !erase_end |=>
    $stable(wel_q) && $stable(erase_kind_q))
    else $error("command accepted during erase");

  // an erase lasts exactly its load, fast or normal by the flag captured at start
  chk_half_length: assert property (s_finish_kind(FBE_ERASE_HALF) |->
    erase_cycles_q == 32'(erase_fast_q ? HALF_BOOST_CYCLES : HALF_CYCLES))
    else $error("half block erase length wrong");
  chk_block_length: assert property (s_finish_kind(FBE_ERASE_BLOCK) |->
    erase_cycles_q == 32'(erase_fast_q ? BLOCK_BOOST_CYCLES : BLOCK_CYCLES))
    else $error("block erase length wrong");
  chk_chip_length: assert property (s_finish_kind(FBE_ERASE_CHIP) |->
    erase_cycles_q == 32'(erase_fast_q ? CHIP_BOOST_CYCLES : CHIP_CYCLES))
    else $error("chip erase length wrong");

  chk_erase_latch: assert property ($rose(ERASE_BUSY_O) |-> $past(wel_q))
    else $error("erase started without write latch");
  chk_boost_byte: assert property ($rose(boost_q) |->
    $past(cmd_single) && $past(frm.opcode) == FACTORY_ERASE_BOOST_CMD)
    else $error("boost flag set by a frame that is not one opcode byte");
  // other commands must leave an armed flag alone until its erase completes
  chk_flag_end_only: assert property ($fell(boost_q) |-> $past(erase_end))
    else $error("boost flag cleared outside erase completion");
  chk_latch_end_only: assert property ($fell(wel_q) |-> $past(erase_end))
    else $error("write latch cleared outside erase completion");
  chk_done_standby: assert property (ERASE_DONE_O |-> STANDBY_O && !ERASE_BUSY_O
    && ERASE_KIND_O == FBE_ERASE_NONE)
    else $error("done pulse without return to standby");
endmodule

//--- fbe_flash_ctrl_tb.sv
`timescale 1ns/1ps
`include "fbe_regs.svh"

module fbe_flash_ctrl_tb;
  import fbe_pkg::*;
  localparam fbe_opcode_type BOOST_CMD = 8'h32;
  localparam fbe_opcode_type WRITE_ENABLE_CMD_CMD = 8'h06;
  localparam fbe_opcode_type HALF_CMD = 8'h52;
  localparam fbe_opcode_type BLOCK_CMD = 8'hD8;
  localparam fbe_opcode_type CHIP_CMD = 8'h60;
  // short times keep the run small; boosted stays below normal as the design demands
  localparam int SEL_US = 1;
  localparam int HALF_US = 3;
  localparam int BLOCK_US = 4;
  localparam int CHIP_US = 5;
  localparam int HALF_FAST_US = 1;
  localparam int BLOCK_FAST_US = 2;
  localparam int CHIP_FAST_US = 2;
  localparam int TIMEOUT = 5000;
  logic clk;
  logic rstn;
  logic sclk;
  logic csn;
  logic si;
  logic latch;
  logic flag;
  logic standby;
  logic deep_pd;
  logic busy;
  logic boosted;
  fbe_erase_type kind;
  logic done;
  int bad_count = 0;
  int num_checks = 0;
  int cycles = 0;
  int busy_cycles = 0;
  int done_count = 0;

  fbe_host_model i_fbe_host_model (.sclk_o(sclk), .csn_o(csn), .si_o(si));

  fbe_flash_ctrl #(.FACTORY_ERASE_BOOST_CMD(BOOST_CMD), .WRITE_ENABLE_CMD(WRITE_ENABLE_CMD_CMD),
    .HALF_BLOCK_ERASE_CMD(HALF_CMD), .BLOCK_ERASE_CMD(BLOCK_CMD), .CHIP_ERASE_CMD(CHIP_CMD),
    .POWER_UP_SELECT_DELAY_US(SEL_US), .HALF_ERASE_US(HALF_US), .BLOCK_ERASE_US(BLOCK_US),
    .CHIP_ERASE_US(CHIP_US), .HALF_ERASE_BOOST_US(HALF_FAST_US), .BLOCK_ERASE_BOOST_US(BLOCK_FAST_US),
    .CHIP_ERASE_BOOST_US(CHIP_FAST_US)) i_fbe_flash_ctrl (
    .CLK_I(clk), .RSTN_I(rstn), .LINK_SCLK_I(sclk), .LINK_CSN_I(csn), .LINK_SI_I(si),
    .WRITE_LATCH_BIT_O(latch), .BOOST_FLAG_O(flag), .STANDBY_O(standby), .DEEP_POWER_DOWN_O(deep_pd),
    .ERASE_BUSY_O(busy), .ERASE_BOOSTED_O(boosted), .ERASE_KIND_O(kind), .ERASE_DONE_O(done));

  initial clk = 1'b0;
  always #50 clk = ~clk;

  always @(posedge clk) begin
    cycles++;
    if (busy === 1'b1) busy_cycles++;
    if (done === 1'b1) done_count++;
    if (cycles == TIMEOUT) begin
      bad_count++;
      print_verdict();
    end
  end

  function automatic int erase_len(input fbe_erase_type k, input logic boost);
    int us;
    case (k)
      FBE_ERASE_HALF: us = boost ? HALF_FAST_US : HALF_US;
      FBE_ERASE_BLOCK: us = boost ? BLOCK_FAST_US : BLOCK_US;
      default: us = boost ? CHIP_FAST_US : CHIP_US;
    endcase
    return us * 1000 / `FBE_CLK_PERIOD_NS;
  endfunction

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL %s expected %0h seen %0h", name, exp, got);
    end
  endtask

  task automatic wait_standby();
    for (int i = 0; i < 300 && standby !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
  endtask

  task automatic run_erase(input fbe_erase_type k, input logic boost);
    fbe_opcode_type op;
    op = (k == FBE_ERASE_HALF) ? HALF_CMD : (k == FBE_ERASE_BLOCK) ? BLOCK_CMD : CHIP_CMD;
    i_fbe_host_model.send_frame({WRITE_ENABLE_CMD_CMD, 24'h0000_00}, 8);
    check("write latch", 1, latch);
    if (boost) begin
      i_fbe_host_model.send_frame({BOOST_CMD, 24'h0000_00}, 8);
      check("boost flag set", 1, flag);
    end
    busy_cycles = 0;
    done_count = 0;
    i_fbe_host_model.send_frame({op, 24'($urandom)}, (k == FBE_ERASE_CHIP) ? 8 : 32);
    check("erase busy", 1, busy);
    check("erase kind", 32'(k), 32'(kind));
    check("boosted timing", 32'(boost), 32'(boosted));
    wait_standby();
    check("erase length", erase_len(k, boost), busy_cycles);
    // done rises together with standby, so it stands now and is tallied one edge later
    check("done pulse", 1, done);
    check("flag after erase", 0, flag);
    check("latch after erase", 0, latch);
    check("kind after erase", 0, 32'(kind));
    @(posedge clk);
    #1;
    check("done pulses", 1, done_count);
    check("done after pulse", 0, done);
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    rstn = 1'b0;
    void'($urandom(32'hdaffb998));
    // chip select stays high through the whole power ramp
    repeat (20) @(posedge clk);
    #1;
    check("standby in reset", 0, standby);
    check("latch in reset", 0, latch);
    check("flag in reset", 0, flag);
    @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    check("standby before delay", 0, standby);
    wait_standby();
    check("standby after delay", 1, standby);
    check("deep power down", 0, deep_pd);
    i_fbe_host_model.send_frame({HALF_CMD, 24'h0012_34}, 32);
    check("erase without latch", 0, busy);
    i_fbe_host_model.send_frame({BOOST_CMD, 24'h0000_00}, 8);
    check("boost without latch", 0, flag);
    for (int k = 1; k < 4; k++) begin
      run_erase(fbe_erase_type'(2'(k)), 1'b1);
    end
    run_erase(fbe_erase_type'(2'(1 + $urandom % 3)), 1'b0);
    i_fbe_host_model.send_frame({WRITE_ENABLE_CMD_CMD, 24'h0000_00}, 8);
    i_fbe_host_model.send_frame({BOOST_CMD, 24'hFF00_00}, 7 + 2 * ($urandom % 2));
    check("boost off boundary", 0, flag);
    i_fbe_host_model.send_frame({BOOST_CMD, 24'h0000_00}, 8);
    check("boost armed", 1, flag);
    @(posedge clk);
    rstn <= 1'b0;
    @(posedge clk);
    #1;
    check("flag at power up", 0, flag);
    check("latch at power up", 0, latch);
    check("standby at power up", 0, standby);
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    wait_standby();
    check("standby again", 1, standby);
    check("flag stays clear", 0, flag);
    print_verdict();
  end
endmodule

//--- fbe_frame_if.sv
`timescale 1ns/1ps
`include "fbe_regs.svh"

interface fbe_frame_if;
  logic [7:0] opcode;
  logic [`FBE_BITCNT_W-1:0] bit_count;

  modport rx (output opcode, output bit_count);
  modport core (input opcode, input bit_count);
endinterface

//--- fbe_host_model.sv
`timescale 1ns/1ps

module fbe_host_model (
  output logic sclk_o,
  output logic csn_o,
  output logic si_o
);
  // serial clock idles low and only runs inside frames
  initial begin
    sclk_o = 1'b0;
    csn_o = 1'b1;
    si_o = 1'b1;
  end

  // msb first; chip select rises right after the last latched bit
  task automatic send_frame(input logic [31:0] word, input int nbits);
    #23 csn_o <= 1'b0;
    for (int i = 0; i < nbits; i++) begin
      si_o <= word[31-i];
      #32 sclk_o <= 1'b1;
      #32 sclk_o <= 1'b0;
    end
    #16 csn_o <= 1'b1;
    // a released data line must not keep showing the last bit
    si_o <= ~si_o;
    // deselect gap of five core cycles, above the three edges the frame takes to be decoded
    #500;
  endtask
endmodule

//--- fbe_link_rx.sv
`timescale 1ns/1ps
`include "fbe_regs.svh"

module fbe_link_rx (
  input wire logic sclk_i,
  input wire logic csn_i,
  input wire logic si_i,
  input wire logic rstn_i,
  fbe_frame_if.rx frm
);
  import fbe_pkg::*;

  localparam logic [`FBE_BITCNT_W-1:0] CNT_MAX = '1;
  localparam logic [`FBE_BITCNT_W-1:0] CNT_OP = `FBE_BITCNT_W'(`FBE_OPCODE_BITS - 1);

  logic active_q;
  logic [6:0] shift_q;
  logic [7:0] opcode_q;
  logic [`FBE_BITCNT_W-1:0] count_q;

  // serial clock stands still outside frames, so the frame start is
  // marked by chip select itself clearing this flag asynchronously
  always_ff @(posedge sclk_i or posedge csn_i) begin
    if (csn_i) begin
      active_q <= 1'b0;
    end else begin
      active_q <= 1'b1;
    end
  end

  always_ff @(posedge sclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      shift_q <= 7'h00;
    end else begin
      shift_q <= {shift_q[5:0], si_i};
    end
  end

  // counter saturates so overlong frames never wrap to a legal length
  always_ff @(posedge sclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      count_q <= '0;
    end else if (!active_q) begin
      count_q <= `FBE_BITCNT_W'(1);
    end else if (count_q != CNT_MAX) begin
      count_q <= count_q + `FBE_BITCNT_W'(1);
    end
  end

  always_ff @(posedge sclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      opcode_q <= `FBE_OPCODE_RST;
    end else if (active_q && count_q == CNT_OP) begin
      opcode_q <= {shift_q, si_i};
    end
  end

  // both words stay frozen from the last edge of a frame until the next frame
  assign frm.opcode = opcode_q;
  assign frm.bit_count = count_q;
endmodule

//--- fbe_pkg.sv
package fbe_pkg;

  typedef enum logic [1:0] {
    FBE_WAIT_POWER,
    FBE_STANDBY,
    FBE_ERASING
  } fbe_state_type;

  typedef enum logic [1:0] {
    FBE_ERASE_NONE,
    FBE_ERASE_HALF,
    FBE_ERASE_BLOCK,
    FBE_ERASE_CHIP
  } fbe_erase_type;

  typedef logic [7:0] fbe_opcode_type;

endpackage

//--- fbe_regs.svh
`ifndef FBE_REGS_SVH
`define FBE_REGS_SVH

// core clock period, used to turn times into cycle counts
`define FBE_CLK_PERIOD_NS 100
// frame lengths, in serial clock edges
`define FBE_OPCODE_BITS 8
`define FBE_ERASE_FRAME_BITS 32
// width of the saturating frame bit counter
`define FBE_BITCNT_W 6
// reset values
`define FBE_LATCH_RST 1'b0
`define FBE_BOOST_RST 1'b0
`define FBE_CSN_IDLE 1'b1
`define FBE_OPCODE_RST 8'h00

`endif
